// >>> mds_bus_model.sv
/*
  far-side model: plays one bus message per go pulse as event pulses
  and flag levels.
  assumes go is a one-cycle pulse given only while busy is low.
*/
`timescale 1ns/1ps
module mds_bus_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic slow,
  input wire logic [20:0] cfg,
  output logic msg_start,
  output logic first_cmd_start,
  output logic cmd1_mid_parity,
  output logic msg_done,
  output logic last_word_end,
  output logic [20:0] lvl,
  output logic busy
);
  logic [5:0] cnt; // cycles into the message
  logic [5:0] len; // cycle of completion
  // slow messages stretch the time before completion
  assign len = slow ? 6'h28 : 6'h06;
  // one message: start, command timing, done, end of last word
  always_ff @(posedge core_clk) begin
    msg_start <= 1'b0;
    first_cmd_start <= 1'b0;
    cmd1_mid_parity <= 1'b0;
    msg_done <= 1'b0;
    last_word_end <= 1'b0;
    // flags are only valid beside done, so they churn otherwise
    lvl <= ~lvl;
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 6'h00;
      lvl <= 21'h0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      cnt <= 6'h00;
      msg_start <= 1'b1;
    end else if (busy) begin
      cnt <= cnt + 6'h01;
      first_cmd_start <= (cnt == 6'h01);
      cmd1_mid_parity <= (cnt == 6'h02);
      // completion with the message's flags
      if (cnt == len) begin
        msg_done <= 1'b1;
        lvl <= cfg;
      end
      last_word_end <= (cnt == len + 6'h01);
      // quiet spell before the next message may start
      busy <= (cnt != len + 6'h04);
    end
  end
endmodule // mds_bus_model

// >>> mds_descriptor.sv
/*
  message descriptor status logic: control word, compare, status word,
  time tag, idle gap, interval copy and the completion actions.
  assumes the protocol engine gives one-cycle event pulses on core_clk
  and holds message flags stable while msg_done is high.
*/
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module mds_descriptor #(
  parameter int LED_CYCLES = mds_pkg::LED_CYCLES_DFLT
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic msg_start,
  input wire logic cmd1_mid_parity,
  input wire logic first_cmd_start,
  input wire logic last_word_end,
  input wire logic [63:0] time_base_in,
  input wire logic msg_done,
  input wire logic [5:0] word_count,
  input wire logic on_bus_a,
  input wire logic two_bus_flag,
  input wire logic wrong_addr_flag,
  input wire logic missing_reply_flag,
  input wire logic count_err_flag,
  input wire logic parity_flag,
  input wire logic manchester_flag,
  input wire logic sync_flag,
  input wire logic undecodable,
  input wire logic [4:0] msg_type,
  input wire logic sequential_capture,
  input wire logic [31:0] interval_timer_in,
  output logic [7:0] cmp_word_index,
  input wire logic [31:0] cmp_word_in,
  input wire logic word_strobe,
  output logic word_keep,
  input wire logic tx_word_req,
  input wire logic [6:0] tx_word_num,
  output logic [4:0] tx_data_slot,
  input wire logic [5:0] cmd_word_count,
  output logic [5:0] tx_total_words,
  output logic inject_en,
  output logic irq_req,
  output logic led_on,
  output logic trig_n
);
  import mds_pkg::*;

  // register file
  logic [31:0] mask_word; // and mask
  logic [31:0] value_word; // compare value
  logic [31:0] ctrl_word; // descriptor control word
  logic [31:0] status_word; // message result word
  logic [31:0] ts_high; // time stamp upper half
  logic [31:0] ts_low; // time stamp lower half
  logic [31:0] gap_word; // idle gap result
  logic [31:0] interval_word; // interval timer copy
  // staging before the status commit
  logic [31:0] stage_status; // status without compare bit
  logic [31:0] stage_interval; // interval value to publish
  logic err_seen; // message completed with an error
  mds_state_e state; // sequencer state
  mds_state_e next_state; // sequencer next state
  // gap timing
  logic [1:0] gap_div; // 25 ns to 100 ns divider
  logic [31:0] gap_count; // running idle time
  // payload words seen in this message
  logic [6:0] words_seen;

  // write decode
  wire wr_mask = reg_wr && (reg_addr == OFS_MASK);
  wire wr_value = reg_wr && (reg_addr == OFS_VALUE);
  wire wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  // commit cycle, the one place actions fire
  wire commit = (state == MDS_COMMIT);
  wire gap_tick = (gap_div == 2'(GAP_DIV - 1));

  // read data mux, unmapped reads zero
  wire [31:0] rd_mux =
    (reg_addr == OFS_MASK) ? mask_word :
    (reg_addr == OFS_VALUE) ? value_word :
    (reg_addr == OFS_CTRL) ? ctrl_word :
    (reg_addr == OFS_STATUS) ? status_word :
    (reg_addr == OFS_TS_HIGH) ? ts_high :
    (reg_addr == OFS_TS_LOW) ? ts_low :
    (reg_addr == OFS_GAP) ? gap_word :
    (reg_addr == OFS_INTERVAL) ? interval_word : WORD_RST;

  // compared word, local words taken from the registers, status and interval from staging
  assign cmp_word_index = ctrl_word[CTL_CMP_LSB +: 8];
  wire [31:0] cmp_sel =
    (cmp_word_index == IDX_MASK) ? mask_word :
    (cmp_word_index == IDX_VALUE) ? value_word :
    (cmp_word_index == IDX_CTRL) ? ctrl_word :
    (cmp_word_index == IDX_STATUS) ? stage_status :
    (cmp_word_index == IDX_TS_HIGH) ? ts_high :
    (cmp_word_index == IDX_TS_LOW) ? ts_low :
    (cmp_word_index == IDX_GAP) ? gap_word :
    (cmp_word_index == IDX_INTERVAL) ? stage_interval : cmp_word_in;
  // masked compare, zero mask bypasses it
  wire cmp_true = (mask_word != WORD_RST) &&
    ((cmp_sel & mask_word) == value_word);

  // error flags in status order
  wire [6:0] err_bits = {sync_flag, manchester_flag, parity_flag,
    count_err_flag, missing_reply_flag, wrong_addr_flag, two_bus_flag};
  wire any_err = (|err_bits) || undecodable;
  // status fields before the compare result
  wire [31:0] new_status = {msg_type, undecodable, 10'h000,
    !any_err, err_bits, 1'b0, on_bus_a, word_count};

  // actions, evaluated on final status in the commit cycle
  wire act_irq = commit && ((ctrl_word[CTL_IRQ_CMP] && cmp_true) ||
    (ctrl_word[CTL_IRQ_ERR] && err_seen) ||
    (ctrl_word[CTL_IRQ_OK] && !err_seen));
  wire act_led = commit && ctrl_word[CTL_LED];
  wire act_trig = commit && ((ctrl_word[CTL_TRIG_ERR] && err_seen) ||
    (ctrl_word[CTL_TRIG_OK] && !err_seen) ||
    (ctrl_word[CTL_TRIG_CMP] && cmp_true));
  logic trig_active; // trigger pulse level
  assign irq_req = act_irq;
  assign trig_n = !trig_active;

  // transmit side controls
  assign inject_en = ctrl_word[CTL_INJECT];
  wire force_en = ctrl_word[CTL_FORCE] && ctrl_word[CTL_INJECT];
  assign tx_total_words = force_en ?
    ctrl_word[CTL_CNT_LSB +: 6] : cmd_word_count;
  // drop payload words past the first 32 of an undecodable message
  assign word_keep = word_strobe &&
    (!undecodable || (words_seen < SPUR_KEEP));

  // sequencer next state, a new start always wins
  always_comb begin
    next_state = state;
    unique case (state)
      MDS_IDLE: next_state = MDS_IDLE;
      MDS_BUSY: if (msg_done) next_state = MDS_FINAL;
      MDS_FINAL: next_state = MDS_COMMIT;
      MDS_COMMIT: next_state = MDS_IDLE;
    endcase
    if (msg_start) next_state = MDS_BUSY;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!rst_n) state <= MDS_IDLE;
    else state <= next_state;
  end

  // software writable registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mask_word <= WORD_RST;
      value_word <= WORD_RST;
      ctrl_word <= WORD_RST;
    end else begin
      if (wr_mask) mask_word <= reg_wdata;
      if (wr_value) value_word <= reg_wdata;
      if (wr_ctrl) ctrl_word <= reg_wdata & CTL_WMASK;
    end
  end

  // read data, valid in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) reg_rdata <= WORD_RST;
    else if (reg_rd) reg_rdata <= rd_mux;
    else reg_rdata <= WORD_RST;
  end

  // staging of status and interval copy at completion
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage_status <= WORD_RST;
      stage_interval <= WORD_RST;
      err_seen <= 1'b0;
    end else if (state == MDS_BUSY && msg_done) begin
      stage_status <= new_status;
      stage_interval <= sequential_capture ?
        interval_timer_in : WORD_RST;
      err_seen <= any_err;
    end
  end

  // status word: all ones at start, final value written last
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      status_word <= WORD_RST;
      interval_word <= WORD_RST;
    end else if (msg_start) begin
      status_word <= STATUS_BUSY;
    end else if (commit) begin
      status_word <= stage_status | {15'h0000, cmp_true, 16'h0000};
      interval_word <= stage_interval;
    end
  end

  // time stamp at mid parity of the first command word
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ts_high <= WORD_RST;
      ts_low <= WORD_RST;
    end else if (cmd1_mid_parity) begin
      ts_high <= time_base_in[63:32];
      ts_low <= time_base_in[31:0];
    end
  end

  // 100 ns divider, restarted at the end of the last word
  always_ff @(posedge core_clk) begin
    if (!rst_n || last_word_end || gap_tick) gap_div <= 2'b00;
    else gap_div <= gap_div + 2'b01;
  end

  // idle time counter, saturating
  always_ff @(posedge core_clk) begin
    if (!rst_n || last_word_end) begin
      gap_count <= WORD_RST;
    end else if (gap_tick && gap_count != STATUS_BUSY) begin
      gap_count <= gap_count + 32'h00000001;
    end
  end

  // gap result taken at the first command word
  always_ff @(posedge core_clk) begin
    if (!rst_n) gap_word <= WORD_RST;
    else if (first_cmd_start) gap_word <= gap_count;
  end

  // payload word counter per message
  always_ff @(posedge core_clk) begin
    if (!rst_n || msg_start) words_seen <= 7'h00;
    else if (word_strobe && words_seen != 7'h7f)
      words_seen <= words_seen + 7'h01;
  end

  // data slot for a transmit word, last slot repeats
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_data_slot <= 5'h00;
    end else if (tx_word_req) begin
      tx_data_slot <= (tx_word_num > LAST_SLOT) ?
        LAST_SLOT[4:0] : tx_word_num[4:0];
    end
  end

  // led flash and trigger pulse timers
  mds_stretch #(.CYCLES(LED_CYCLES)) u_led (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .fire(act_led),
    .active(led_on)
  );
  mds_stretch #(.CYCLES(TRIG_CYCLES)) u_trig (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .fire(act_trig),
    .active(trig_active)
  );

  // checks
  property p_cmp_irq;
    @(posedge core_clk) disable iff (!rst_n)
    commit && ctrl_word[CTL_IRQ_CMP] && cmp_true |-> irq_req;
  endproperty
  a_cmp_irq: assert property (p_cmp_irq)
    else $error("compare interrupt missing");

  property p_led;
    @(posedge core_clk) disable iff (!rst_n)
    commit && ctrl_word[CTL_LED] |=> led_on [*8];
  endproperty
  a_led: assert property (p_led)
    else $error("led flash missing");

  property p_trig_err;
    @(posedge core_clk) disable iff (!rst_n)
    commit && ctrl_word[CTL_TRIG_ERR] && err_seen |=> !trig_n [*8];
  endproperty
  a_trig_err: assert property (p_trig_err)
    else $error("error trigger missing");

  property p_trig_ok;
    @(posedge core_clk) disable iff (!rst_n)
    commit && ctrl_word[CTL_TRIG_OK] && !err_seen
      |=> !trig_n ##40 trig_n || act_trig;
  endproperty
  a_trig_ok: assert property (p_trig_ok)
    else $error("clean trigger width wrong");

  property p_busy_ones;
    @(posedge core_clk) disable iff (!rst_n)
    msg_start |=> status_word == STATUS_BUSY;
  endproperty
  a_busy_ones: assert property (p_busy_ones)
    else $error("status not all ones at start");

  property p_force;
    @(posedge core_clk) disable iff (!rst_n)
    !ctrl_word[CTL_INJECT] |-> !inject_en &&
      tx_total_words == cmd_word_count;
  endproperty
  a_force: assert property (p_force)
    else $error("forced count without injection enable");

  property p_keep;
    @(posedge core_clk) disable iff (!rst_n)
    undecodable && words_seen >= SPUR_KEEP |-> !word_keep;
  endproperty
  a_keep: assert property (p_keep)
    else $error("undecodable word kept past 32");

  property p_ok_bit;
    @(posedge core_clk) disable iff (!rst_n)
    commit |=> status_word[ST_OK] ==
      !((|status_word[14:8]) || status_word[ST_SPURIOUS]);
  endproperty
  a_ok_bit: assert property (p_ok_bit)
    else $error("no error bit inconsistent");

  property p_time;
    @(posedge core_clk) disable iff (!rst_n)
    cmd1_mid_parity |=> {ts_high, ts_low} == $past(time_base_in);
  endproperty
  a_time: assert property (p_time)
    else $error("time stamp not latched");

  property p_once;
    @(posedge core_clk) disable iff (!rst_n)
    irq_req |=> !irq_req;
  endproperty
  a_once: assert property (p_once)
    else $error("action fired twice");

  c_done: cover property (@(posedge core_clk) disable iff (!rst_n)
    state == MDS_BUSY && msg_done ##2 commit);
  c_cmp: cover property (@(posedge core_clk) disable iff (!rst_n)
    commit && cmp_true);
  c_trig: cover property (@(posedge core_clk) disable iff (!rst_n)
    act_trig && err_seen);
endmodule // mds_descriptor

// >>> mds_pkg.sv
/*
  shared constants for the message descriptor status logic:
  register offsets, field positions, reset values and timing counts.
  assumes a 40 MHz core clock.
*/
package mds_pkg;
  // clock period in ns
  localparam int CLK_PERIOD_NS = 25;
  // register byte offsets inside the descriptor
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_VALUE = 8'h18;
  localparam logic [7:0] OFS_CTRL = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_TS_HIGH = 8'h24;
  localparam logic [7:0] OFS_TS_LOW = 8'h28;
  localparam logic [7:0] OFS_GAP = 8'h2c;
  localparam logic [7:0] OFS_INTERVAL = 8'h30;
  // control word fields
  localparam int CTL_INJECT = 1;
  localparam int CTL_IRQ_ERR = 4;
  localparam int CTL_IRQ_OK = 5;
  localparam int CTL_IRQ_CMP = 6;
  localparam int CTL_LED = 10;
  localparam int CTL_TRIG_ERR = 13;
  localparam int CTL_TRIG_OK = 14;
  localparam int CTL_TRIG_CMP = 15;
  localparam int CTL_CMP_LSB = 16;
  localparam int CTL_CNT_LSB = 24;
  localparam int CTL_FORCE = 30;
  // writable control bits, the rest read zero
  localparam logic [31:0] CTL_WMASK = 32'h7fffe472;
  // status word fields
  localparam int ST_BUS_A = 6;
  localparam int ST_ERR_LSB = 8;
  localparam int ST_OK = 15;
  localparam int ST_CMP = 16;
  localparam int ST_SPURIOUS = 26;
  localparam int ST_TYPE_LSB = 27;
  // reset and in-progress values
  localparam logic [31:0] WORD_RST = 32'h00000000;
  localparam logic [31:0] STATUS_BUSY = 32'hffffffff;
  // payload words kept for an undecodable message
  localparam logic [6:0] SPUR_KEEP = 7'h20;
  // last data slot, repeated for longer forced counts
  localparam logic [6:0] LAST_SLOT = 7'h1f;
  // descriptor word indices held locally
  localparam logic [7:0] IDX_MASK = 8'h05;
  localparam logic [7:0] IDX_VALUE = 8'h06;
  localparam logic [7:0] IDX_CTRL = 8'h07;
  localparam logic [7:0] IDX_STATUS = 8'h08;
  localparam logic [7:0] IDX_TS_HIGH = 8'h09;
  localparam logic [7:0] IDX_TS_LOW = 8'h0a;
  localparam logic [7:0] IDX_GAP = 8'h0b;
  localparam logic [7:0] IDX_INTERVAL = 8'h0c;
  // idle gap unit
  localparam int GAP_UNIT_NS = 100;
  localparam int GAP_DIV = GAP_UNIT_NS / CLK_PERIOD_NS;
  // trigger pulse width, a least time, rounded up
  localparam int TRIG_NS = 1000;
  localparam int TRIG_CYCLES = (TRIG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // led flash length
  localparam int LED_MS = 250;
  localparam int LED_CYCLES_DFLT = LED_MS * (1000000 / CLK_PERIOD_NS);
  // descriptor sequencer states
  typedef enum logic [1:0] {
    MDS_IDLE = 2'b00,
    MDS_BUSY = 2'b01,
    MDS_FINAL = 2'b10,
    MDS_COMMIT = 2'b11
  } mds_state_e;
endpackage

// >>> mds_stretch.sv
/*
  fixed-length pulse stretcher: a one-cycle fire starts a level of
  CYCLES cycles. assumes fire is a single-cycle pulse on core_clk.
*/
`timescale 1ns/1ps
module mds_stretch #(
  parameter int CYCLES = 40
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic fire,
  output logic active
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);
  localparam logic [W-1:0] ONE = W'(1);
  // cycles left in the pulse
  logic [W-1:0] left;
  // a new fire restarts the full length
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      left <= '0;
    end else if (fire) begin
      left <= LOAD;
    end else if (left != '0) begin
      left <= left - ONE;
    end
  end
  // level while counting down
  assign active = (left != '0);
endmodule // mds_stretch

// >>> tb_mds_descriptor.sv
/*
  self-checking bench for the descriptor status logic: registers,
  forced counts, data slots and random bus messages.
  assumes mds_pkg and the far-side model mds_bus_model.
*/
`timescale 1ns/1ps
module tb_mds_descriptor;
  import mds_pkg::*;
  localparam int LEDC = 50; // short led flash for simulation
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [20:0] cfg = 21'h0; // flags of the next message
  logic [20:0] lvl;
  logic busy, ms, fcs, mp, md, lwe;
  logic [63:0] tbase = 64'h0; // free running time base
  logic [31:0] itv = 32'h0;
  logic [31:0] cin = 32'h0; // shared memory compare word
  logic req = 1'b0;
  logic [6:0] num = 7'h0;
  logic [5:0] cwc = 6'h0;
  logic ws = 1'b0; // payload word strobe
  logic [6:0] nw = 7'h0; // strobes since message start
  logic [7:0] cwi;
  logic keep, inj, irq, led, trig_n;
  logic [4:0] slot;
  logic [5:0] total;
  logic [31:0] seed = 32'h1307;
  logic [31:0] gc = 32'h0; // cycles since last word end
  logic [63:0] exp_ts = 64'h0;
  logic [31:0] exp_gap = 32'h0;
  logic [7:0] offs [9] = '{OFS_MASK, OFS_VALUE, OFS_CTRL, OFS_STATUS,
    OFS_TS_HIGH, OFS_TS_LOW, OFS_GAP, OFS_INTERVAL, 8'h40};
  logic [6:0] nums [5] = '{7'h00, 7'h1f, 7'h20, 7'h41, 7'h05};
  int n_irq = 0, n_trig = 0, n_led = 0;
  int bad_count = 0;
  int n_compared = 0;

  always #12.5 core_clk = ~core_clk;
  // time base and bench-side monitors
  always @(posedge core_clk) begin
    tbase <= tbase + 64'h1;
    gc <= lwe ? 32'h0 : gc + 32'h1;
    nw <= ms ? 7'h00 : nw + {6'h00, ws};
    if (mp) exp_ts <= tbase;
    if (fcs) exp_gap <= gc / 4;
    n_irq <= n_irq + irq;
    n_trig <= n_trig + !trig_n;
    n_led <= n_led + led;
  end

  // payload words past 32 of an undecodable message are dropped
  always @(negedge core_clk) begin
    if (rst_n) chk("keep", keep, ws && (!lvl[13] || nw < 7'h20));
  end

  mds_bus_model mds_bus_model_i (
    .core_clk(core_clk), .rst_n(rst_n), .go(go), .slow(slow),
    .cfg(cfg), .msg_start(ms), .first_cmd_start(fcs),
    .cmd1_mid_parity(mp), .msg_done(md), .last_word_end(lwe),
    .lvl(lvl), .busy(busy));

  mds_descriptor #(.LED_CYCLES(LEDC)) mds_descriptor_i (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .msg_start(ms), .cmd1_mid_parity(mp),
    .first_cmd_start(fcs), .last_word_end(lwe), .time_base_in(tbase),
    .msg_done(md), .word_count(lvl[5:0]), .on_bus_a(lvl[14]),
    .two_bus_flag(lvl[6]), .wrong_addr_flag(lvl[7]),
    .missing_reply_flag(lvl[8]), .count_err_flag(lvl[9]),
    .parity_flag(lvl[10]), .manchester_flag(lvl[11]),
    .sync_flag(lvl[12]), .undecodable(lvl[13]), .msg_type(lvl[19:15]),
    .sequential_capture(lvl[20]), .interval_timer_in(itv),
    .cmp_word_index(cwi), .cmp_word_in(cin), .word_strobe(ws),
    .word_keep(keep), .tx_word_req(req), .tx_word_num(num),
    .tx_data_slot(slot), .cmd_word_count(cwc), .tx_total_words(total),
    .inject_en(inj), .irq_req(irq), .led_on(led), .trig_n(trig_n));

  // xorshift source, fixed seed
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one random message with compare against a shared memory word or the local control word
  task automatic run_msg(input bit first);
    logic [31:0] c, m, v, w, f, d, st;
    logic e, cm;
    // compare either a shared memory word or the local control word
    c = xs();
    c = (c & 32'h0000e470) | (c[0] ? 32'h00070000 : 32'h00400000);
    m = xs();
    if (m[3:0] == 4'h0) m = 32'h0; // zero mask bypasses compare
    w = c[16] ? c : xs();
    v = m[4] ? (w & m) : xs();
    f = xs();
    wr(OFS_MASK, m);
    wr(OFS_VALUE, v);
    wr(OFS_CTRL, c);
    @(posedge core_clk);
    cin <= w;
    cfg <= f[20:0];
    itv <= xs();
    slow <= f[22];
    ws <= f[21];
    // line up the gap so both tick phases agree
    @(negedge core_clk);
    while (gc[1:0] != 2'd1) @(negedge core_clk);
    @(posedge core_clk);
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    rd(OFS_STATUS, d);
    chk("busy status", d, STATUS_BUSY);
    n_irq = 0;
    n_trig = 0;
    n_led = 0;
    while (busy) @(posedge core_clk);
    ws <= 1'b0;
    repeat (60) @(posedge core_clk);
    e = (f[13:6] != 8'h0);
    cm = (m != 32'h0) && ((w & m) == v);
    st = {f[19:15], f[13], 9'h0, cm, !e, f[12:6], 1'b0, f[14], f[5:0]};
    rd(OFS_STATUS, d);
    chk("status", d, st);
    chk("status cmp", d[16], cm);
    rd(OFS_TS_HIGH, d);
    chk("ts high", d, exp_ts[63:32]);
    rd(OFS_TS_LOW, d);
    chk("ts low", d, exp_ts[31:0]);
    rd(OFS_GAP, d);
    if (!first) chk("gap", d, exp_gap);
    rd(OFS_INTERVAL, d);
    chk("interval", d, f[20] ? itv : 32'h0);
    chk("irq", n_irq, (c[6] && cm) || (c[4] && e) || (c[5] && !e));
    chk("trig", n_trig, ((c[13] && e) || (c[14] && !e) || (c[15] && cm))
        ? TRIG_CYCLES : 0);
    chk("led", n_led, c[10] ? LEDC : 0);
  endtask

  // main sequence
  initial begin
    logic [31:0] d, c, r;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk("trig idle", trig_n, 1'b1);
    chk("led idle", led, 1'b0);
    // reset values and an unmapped address
    foreach (offs[i]) begin
      rd(offs[i], d);
      chk("reset read", d, 32'h0);
    end
    wr(OFS_STATUS, xs());
    rd(OFS_STATUS, d);
    chk("status ro", d, 32'h0);
    // control word, compare index, injection gate, forced count
    for (int i = 0; i < 4; i++) begin
      c = xs();
      c[30] = i[1];
      c[1] = i[0];
      wr(OFS_CTRL, c);
      rd(OFS_CTRL, d);
      chk("ctrl", d, c & CTL_WMASK);
      r = xs();
      @(posedge core_clk);
      cwc <= r[5:0];
      @(negedge core_clk);
      chk("index", cwi, c[23:16]);
      chk("inject", inj, c[1]);
      chk("total", total, (i == 3) ? c[29:24] : r[5:0]);
    end
    // data slots repeat the last word past 32
    foreach (nums[i]) begin
      @(posedge core_clk);
      req <= 1'b1;
      num <= nums[i];
      @(posedge core_clk);
      req <= 1'b0;
      @(negedge core_clk);
      chk("slot", slot, (nums[i] > 7'h1f) ? 5'h1f : nums[i][4:0]);
    end
    for (int i = 0; i < 14; i++) run_msg(i == 0);
    end_of_test();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    end_of_test();
  end
endmodule // tb_mds_descriptor
